// >>> include/rws_regs.svh
// Register offsets, field positions, reset values and fetch constants for
// the rotated main-window address block.
// Assumes a 20 MHz display clock and a dword-wide display buffer.
//
// Overview of operation
// - Bits 17-16 of the display configuration register pick 0, 90, 180 or 270 degree rotation.
// - The start register holds a dword address into the display buffer, zero being its first word.
// - Bits 9-0 of the line register give the dwords in one image line.
// - A line wider than the panel is accepted and only the panel-sized part is shown.
// - Rotation works at 1, 2, 4, 8 and 16 bits per pixel.
`ifndef RWS_REGS_SVH
`define RWS_REGS_SVH
`define RWS_OFS_CONFIG 8'h10
`define RWS_OFS_START 8'h40
`define RWS_OFS_LINE 8'h44
`define RWS_OFS_STATUS 8'h48
`define RWS_OFS_PANEL 8'h4C
`define RWS_OFS_CONTROL 8'h50
`define RWS_CFG_ROT_HI 17
`define RWS_CFG_ROT_LO 16
`define RWS_CFG_BPP_HI 4
`define RWS_CFG_BPP_LO 0
`define RWS_CFG_MASK 32'h03FB001F
`define RWS_LINE_HI 9
`define RWS_START_W 17
`define RWS_CONFIG_RESET 32'h00000000
`define RWS_START_RESET 17'h00000
`define RWS_LINE_RESET 10'h000
`define RWS_PANEL_RESET 32'h00000000
`endif

// >>> include/rws_pkg.sv
// Types shared by the rotated main-window address block.
// Assumes rws_regs.svh is included by the modules that use widths.
package rws_pkg;
   typedef enum logic [1:0] {
      rws_rot_0_type_val = 2'h0,
      rws_rot_90_type_val = 2'h1,
      rws_rot_180_type_val = 2'h2,
      rws_rot_270_type_val = 2'h3
   } rws_rot_type;
   typedef enum logic [2:0] {
      RWS_IDLE = 3'h1,
      RWS_FETCH = 3'h2,
      RWS_DONE = 3'h4
   } rws_state_type;
endpackage : rws_pkg

// >>> include/rws_fetch_if.sv
// Carrier between the register file and the fetch address walker.
// Assumes both ends share clk and nrst.
`timescale 1ns/1ps
interface rws_fetch_if;
   logic [1:0] rotation;
   logic [16:0] start_dword;
   logic [9:0] line_dwords;
   logic [9:0] cols;
   logic [9:0] rows;
   logic go;
   logic busy;
   logic addr_valid;
   logic [16:0] addr;
   logic frame_done;
   modport ctrl (output rotation, start_dword, line_dwords, cols, rows, go,
      input busy, addr_valid, addr, frame_done);
   modport walk (input rotation, start_dword, line_dwords, cols, rows, go,
      output busy, addr_valid, addr, frame_done);
endinterface : rws_fetch_if

// >>> hw/rws_walker.sv
// Frame fetch address walker: emits one dword address per cycle.
// Assumes settings stay still while busy; cols is a nonzero dword count and rows a nonzero line count.
`timescale 1ns/1ps
module rws_walker
(
   input wire logic clk,
   input wire logic nrst,
   rws_fetch_if.walk f
);
   import rws_pkg::*;
   rws_state_type state;
   logic [16:0] line_base;
   logic [9:0] col;
   logic [9:0] row;
   logic last_col;
   logic last_row;

   // Position counters hit their ends
   assign last_col = (col == f.cols - 10'h001);
   assign last_row = (row == f.rows - 10'h001);
   assign f.busy = (state == RWS_FETCH);
   assign f.addr_valid = (state == RWS_FETCH);

   // Step within a line: forward at 0/270, backward at 90/180 (start is the last dword)
   function automatic logic [16:0] step_in(input logic [1:0] rot, input logic [16:0] a);
      step_in = (rot == 2'h1 || rot == 2'h2) ? a - 17'h00001 : a + 17'h00001;
   endfunction : step_in

   // Step between lines: down at 0/90, up at 180/270
   function automatic logic [16:0] step_line(input logic [1:0] rot, input logic [16:0] a,
      input logic [9:0] ofs);
      step_line = (rot[1]) ? a - {7'h00, ofs} : a + {7'h00, ofs};
   endfunction : step_line

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= RWS_IDLE;
         line_base <= 17'h00000;
         f.addr <= 17'h00000;
         col <= 10'h000;
         row <= 10'h000;
      end
      else
      begin
         case (state)
            RWS_IDLE:
            begin
               if (f.go)
               begin
                  state <= RWS_FETCH;
                  line_base <= f.start_dword;
                  f.addr <= f.start_dword;
                  col <= 10'h000;
                  row <= 10'h000;
               end
            end
            RWS_FETCH:
            begin
               if (last_col)
               begin
                  col <= 10'h000;
                  if (last_row)
                  begin
                     state <= RWS_DONE;
                  end
                  else
                  begin
                     row <= row + 10'h001;
                     line_base <= step_line(f.rotation, line_base, f.line_dwords);
                     f.addr <= step_line(f.rotation, line_base, f.line_dwords);
                  end
               end
               else
               begin
                  col <= col + 10'h001;
                  f.addr <= step_in(f.rotation, f.addr);
               end
            end
            RWS_DONE: state <= RWS_IDLE;
            default: state <= RWS_IDLE;
         endcase
      end
   end

   assign f.frame_done = (state == RWS_DONE);
endmodule : rws_walker

// >>> hw/rws_top.sv
// Main-window rotation registers and frame fetch address generator.
// Assumes a plain register port on clk; reads return data one cycle later.
`timescale 1ns/1ps
`include "rws_regs.svh"
module rws_top
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic frame_start,
   output logic fetch_valid,
   output logic [16:0] fetch_addr,
   output logic fetch_busy,
   output logic [1:0] rotation_select,
   output logic overlay_window_enable,
   output logic software_colour_invert
);
   import rws_pkg::*;
   logic [31:0] display_configuration;
   logic [16:0] main_image_start_dword;
   logic [9:0] main_image_line_dwords;
   logic [31:0] panel_size;
   logic [9:0] frame_count;
   logic frame_start_s1;
   logic frame_start_s2;
   logic frame_start_d;
   logic [4:0] bpp;
   logic [9:0] width_dw;
   logic [9:0] height_dw;
   rws_fetch_if fi ();

   // Dwords covering a pixel count at the current depth
   function automatic logic [9:0] px_to_dw(input logic [9:0] px, input logic [4:0] depth);
      logic [9:0] r;
      r = 10'h000;
      case (depth)
         5'h01: r = 10'(({5'h00, px} + 15'h001F) >> 5);
         5'h02: r = 10'(({5'h00, px} + 15'h000F) >> 4);
         5'h04: r = 10'(({5'h00, px} + 15'h0007) >> 3);
         5'h08: r = 10'(({5'h00, px} + 15'h0003) >> 2);
         default: r = 10'(({5'h00, px} + 15'h0001) >> 1);
      endcase
      px_to_dw = (r == 10'h000) ? 10'h001 : r;
   endfunction : px_to_dw

   // Register writes; reserved bits are dropped
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         display_configuration <= `RWS_CONFIG_RESET;
         main_image_start_dword <= `RWS_START_RESET;
         main_image_line_dwords <= `RWS_LINE_RESET;
         panel_size <= `RWS_PANEL_RESET;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `RWS_OFS_CONFIG: display_configuration <= reg_wdata & `RWS_CFG_MASK;
            `RWS_OFS_START: main_image_start_dword <= reg_wdata[`RWS_START_W-1:0];
            `RWS_OFS_LINE: main_image_line_dwords <= reg_wdata[`RWS_LINE_HI:0];
            `RWS_OFS_PANEL: panel_size <= reg_wdata & 32'h03FF03FF;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         reg_rdata <= 32'h00000000;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            `RWS_OFS_CONFIG: reg_rdata <= display_configuration;
            `RWS_OFS_START: reg_rdata <= {15'h0000, main_image_start_dword};
            `RWS_OFS_LINE: reg_rdata <= {22'h000000, main_image_line_dwords};
            `RWS_OFS_STATUS: reg_rdata <= {21'h000000, fi.busy, frame_count};
            `RWS_OFS_PANEL: reg_rdata <= panel_size;
            default: reg_rdata <= 32'h00000000;
         endcase
      end
      else
      begin
         reg_rdata <= 32'h00000000;
      end
   end

   // Frame strobe from the panel timing pin, synchronised then edge-detected
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         frame_start_s1 <= 1'b0;
         frame_start_s2 <= 1'b0;
         frame_start_d <= 1'b0;
      end
      else
      begin
         frame_start_s1 <= frame_start;
         frame_start_s2 <= frame_start_s1;
         frame_start_d <= frame_start_s2;
      end
   end

   // Completed frame counter for software
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         frame_count <= 10'h000;
      end
      else if (fi.frame_done)
      begin
         frame_count <= frame_count + 10'h001;
      end
   end

   assign bpp = display_configuration[`RWS_CFG_BPP_HI:`RWS_CFG_BPP_LO];
   assign rotation_select = display_configuration[`RWS_CFG_ROT_HI:`RWS_CFG_ROT_LO];
   assign overlay_window_enable = display_configuration[19];
   assign software_colour_invert = display_configuration[20];
   assign width_dw = px_to_dw(panel_size[9:0], bpp);
   assign height_dw = px_to_dw(panel_size[25:16], bpp);

   // visible dwords only, extra line width skipped
   assign fi.cols = rotation_select[0] ? height_dw : width_dw;
   assign fi.rows = rotation_select[0] ? panel_size[9:0] : panel_size[25:16];
   assign fi.rotation = rotation_select;
   assign fi.start_dword = main_image_start_dword;
   assign fi.line_dwords = main_image_line_dwords;
   assign fi.go = frame_start_s2 & ~frame_start_d & (fi.rows != 10'h000);

   rws_walker u_walker
   (
      .clk(clk),
      .nrst(nrst),
      .f(fi)
   );

   assign fetch_valid = fi.addr_valid;
   assign fetch_addr = fi.addr;
   assign fetch_busy = fi.busy;
endmodule : rws_top

// >>> sim/rws_chk.sv
// Checker for the rotation block: register port, rotation field, fetch order.
// Assumes it is bound to rws_top and sees only its ports.
`timescale 1ns/1ps
module rws_chk
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic frame_start,
   input wire logic fetch_valid,
   input wire logic [16:0] fetch_addr,
   input wire logic fetch_busy,
   input wire logic [1:0] rotation_select,
   input wire logic overlay_window_enable,
   input wire logic software_colour_invert
);
   logic [16:0] start_sh;
   logic [9:0] line_sh;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Shadows of start and line, so fetch and reads can be judged
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         start_sh <= 17'h00000;
         line_sh <= 10'h000;
      end
      else if (reg_wr && reg_addr == 8'h40)
         start_sh <= reg_wdata[16:0];
      else if (reg_wr && reg_addr == 8'h44)
         line_sh <= reg_wdata[9:0];
   end
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data not zero outside a read");
   rot_take_a: assert property (reg_wr && reg_addr == 8'h10 |=>
      rotation_select == $past(reg_wdata[17:16])) else $error("rotation not taken");
   rot_hold_a: assert property (!(reg_wr && reg_addr == 8'h10) |=>
      $stable(rotation_select)) else $error("rotation changed without write");
   start_read_a: assert property (reg_rd && reg_addr == 8'h40 |=>
      reg_rdata == {15'h0000, start_sh}) else $error("start readback wrong");
   line_read_a: assert property (reg_rd && reg_addr == 8'h44 |=>
      reg_rdata == {22'h000000, line_sh}) else $error("line readback wrong");
   busy_valid_a: assert property (fetch_busy == fetch_valid)
      else $error("busy and valid differ");
   first_addr_a: assert property ($rose(fetch_valid) |-> fetch_addr == start_sh)
      else $error("frame did not begin at start");
   up_order_a: assert property (fetch_valid && $past(fetch_valid) &&
      rotation_select == 2'h0 |-> fetch_addr > $past(fetch_addr)) else $error("rot0 not rising");
   down_order_a: assert property (fetch_valid && $past(fetch_valid) &&
      rotation_select == 2'h2 |-> fetch_addr < $past(fetch_addr)) else $error("rot180 not falling");
   cover property ($rose(fetch_valid) && rotation_select == 2'h3);
   cover property (reg_rd && reg_addr == 8'h40);
   cover property (reg_wr && reg_addr == 8'h10);
endmodule : rws_chk
bind rws_top rws_chk i_chk (.*);

// >>> sim/rws_host.sv
// Host software model: register port master and start address arithmetic.
// Assumes the slave answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module rws_host
(
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One write cycle, then release
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // start per rotation; integer division truncates
   function automatic int start_for(int rot, int b, int w, int h, int bpp, int line);
      int s;
      s = line * 4;
      case (rot)
         0: return b / 4;
         1: return (b + h * bpp / 8 + ((4 - h * bpp / 8) & 3)) / 4 - 1;
         2: return (b + s * (h - 1) + w * bpp / 8 + ((4 - w * bpp / 8) & 3)) / 4 - 1;
         default: return (b + (w - 1) * s) / 4;
      endcase
   endfunction : start_for
endmodule : rws_host

// >>> sim/rotated_window_address_setup_tb_top.sv
// Self-checking bench: registers, rotation field and fetch walks.
// Assumes rws_top with a 20 MHz clock and the host model on its port.
`timescale 1ns/1ps
module rotated_window_address_setup_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic frame_start = 1'b0;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, fetch_valid, fetch_busy, ovl, inv;
   logic [16:0] fetch_addr;
   logic [1:0] rot_sel;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   rws_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   rws_top i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_busy(fetch_busy),
      .rotation_select(rot_sel), .overlay_window_enable(ovl), .software_colour_invert(inv));
   task automatic tally_and_finish;
      if (bad_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_reg
   task automatic cmp_addr(input logic [16:0] got, input logic [16:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_addr
   // Panel 8x2 at 16 bpp, line 6 dwords (wider than panel), image at byte 400h
   task automatic walk(input int rot);
      int s, cols, rows, n, k;
      s = i_host.start_for(rot, 32'h400, 8, 2, 16, 6);
      cols = rot[0] ? 1 : 4;
      rows = rot[0] ? 8 : 2;
      n = 0;
      i_host.wr(8'h10, {14'h0000, rot[1:0], 16'h0010});
      i_host.wr(8'h40, s);
      frame_start <= 1'b1;
      for (k = 0; k < 20 && fetch_valid !== 1'b1; k++)
         @(posedge clk) #1;
      while (fetch_valid === 1'b1)
      begin
         cmp_addr(fetch_addr, s + ((rot == 2 || rot == 3) ? -6 : 6) * (n / cols)
            + ((rot == 1 || rot == 2) ? -1 : 1) * (n % cols));
         cmp_reg({31'h00000000, fetch_busy}, 32'h00000001);
         n++;
         @(posedge clk) #1;
      end
      cmp_reg(n, cols * rows);
      frame_start <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : walk
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      // Reset values of the three registers
      i_host.rd(8'h10, d);
      cmp_reg(d, 32'h00000000);
      i_host.rd(8'h40, d);
      cmp_reg(d, 32'h00000000);
      i_host.rd(8'h44, d);
      cmp_reg(d, 32'h00000000);
      // Every rotation code reaches the pin and reads back
      for (int r = 0; r < 4; r++)
      begin
         i_host.wr(8'h10, {14'h0000, r[1:0], 16'h0000});
         i_host.rd(8'h10, d);
         cmp_reg(d, {14'h0000, r[1:0], 16'h0000});
         cmp_reg({30'h00000000, rot_sel}, {30'h00000000, r[1:0]});
      end
      // Reserved bits read zero, fields keep the last value
      i_host.wr(8'h10, 32'hFFFFFFFF);
      i_host.rd(8'h10, d);
      cmp_reg(d, 32'h03FB001F);
      cmp_reg({30'h00000000, ovl, inv}, 32'h00000003);
      i_host.wr(8'h40, 32'hFFFFFFFF);
      i_host.wr(8'h44, 32'hFFFFFFFF);
      i_host.rd(8'h40, d);
      cmp_reg(d, 32'h0001FFFF);
      i_host.rd(8'h44, d);
      cmp_reg(d, 32'h000003FF);
      i_host.rd(8'h20, d);
      cmp_reg(d, 32'h00000000);
      // panel 8x2 at 16 bpp, both multiples of 32/bpp
      // image width 12 px covers both, multiple of 2
      // line offset is image width over 32/bpp: 6 dwords at 16 bpp
      i_host.wr(8'h44, 32'h00000006);
      i_host.wr(8'h4C, 32'h00020008);
      for (int r = 0; r < 4; r++)
         walk(r);
      // Four walks completed, walker idle
      i_host.rd(8'h48, d);
      cmp_reg(d, 32'h00000004);
      tally_and_finish();
   end
endmodule : rotated_window_address_setup_tb_top
